// File: pkg/acp_pkg.sv
// Shared constants, carriers and state codes of the amplifier control serial port
package acp_pkg;

	// Target address: fixed upper five bits, strapped low two bits
	localparam logic [4:0] ACP_ADDR_FIXED = 5'h1a;
	localparam logic [3:0] ACP_BYTE_BITS = 4'h8;
	localparam logic [2:0] ACP_LAST_BIT = 3'h7;
	localparam logic [1:0] ACP_NUM_BYTES = 2'h2;

	// instruction_control_one fields
	localparam int ACP_C1_SUPPLY_THR = 7;
	localparam int ACP_C1_DIAG_EN = 6;
	localparam int ACP_C1_OFFSET_EN = 5;
	localparam int ACP_C1_GAIN_16DB = 4;
	localparam int ACP_C1_UNMUTE = 2;
	localparam int ACP_C1_CLIP_LEVEL = 0;
	localparam logic [7:0] ACP_C1_MASK = 8'hf5;
	localparam logic [7:0] ACP_C1_RESET = 8'h00;

	// instruction_control_two fields
	localparam int ACP_C2_CUR_THR_LOW = 7;
	localparam int ACP_C2_FAST_MUTE = 5;
	localparam int ACP_C2_RUN = 4;
	localparam int ACP_C2_LINE_DRV = 3;
	localparam int ACP_C2_CUR_DIAG = 2;
	localparam int ACP_C2_HIGH_EFF = 1;
	localparam logic [7:0] ACP_C2_MASK = 8'hbe;
	localparam logic [7:0] ACP_C2_RESET = 8'h00;

	// diag_result_one: cycle-terminated flag position
	localparam int ACP_D1_DONE = 6;
	localparam logic [7:0] ACP_RES_RESET = 8'h00;

	// Pin levels as seen by the logic (comparator outputs and bus lines)
	typedef struct packed {
		logic scl;
		logic sda;
		logic if_sel;
		logic sleep_on;
		logic sleep_hv;
		logic mute_on;
		logic supply_low;
		logic short_gnd;
		logic short_vcc;
		logic short_across;
		logic meas_done;
		logic [1:0] strap;
	} acp_pins_s;

	typedef struct packed {
		logic amp_on;
		logic play;
		logic high_eff;
		logic standard;
	} acp_mode_s;

	typedef enum logic [6:0] {
		ACP_IDLE = 7'h01,
		ACP_ADDR = 7'h02,
		ACP_AACK = 7'h04,
		ACP_WRX = 7'h08,
		ACP_WACK = 7'h10,
		ACP_RDX = 7'h20,
		ACP_RACK = 7'h40
	} acp_state_e;

endpackage

// File: hw/acp_sync.sv
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module acp_sync #(
	parameter int W = 13
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} acp_sync_s;

	acp_sync_s q, d;

	// First stage feeds only the second stage
	always_comb begin
		d = q;
		d.s1 = async_in;
		d.s2 = q.s1;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;
endmodule

// File: hw/acp_mode_sel.sv
// Operating mode selection from pins and instruction bytes
`timescale 1ns/1ps
module acp_mode_sel
	import acp_pkg::*;
(
	input acp_pkg::acp_pins_s pins,
	input wire logic [7:0] ctl_one,
	input wire logic [7:0] ctl_two,
	output acp_pkg::acp_mode_s mode
);
	always_comb begin
		mode = '0;
		if (pins.if_sel) begin
			// Standby pin low always wins; turn-on needs the bus command
			mode.amp_on = pins.sleep_on && ctl_two[ACP_C2_RUN];
			mode.play = mode.amp_on && pins.mute_on && ctl_one[ACP_C1_UNMUTE];
			mode.high_eff = mode.amp_on && ctl_two[ACP_C2_HIGH_EFF] && !pins.supply_low;
		end else begin
			mode.amp_on = pins.sleep_on;
			mode.play = mode.amp_on && pins.mute_on;
			// Between 5 V and 7 V the comparator stays low, so standard mode holds
			mode.high_eff = mode.amp_on && pins.sleep_hv && !pins.supply_low;
		end
		mode.standard = mode.amp_on && !mode.high_eff;
	end
endmodule

// File: hw/acp_top.sv
// Serial target port and mode control of a dual-bridge amplifier
//
// Behaviour
// - Serial port works only while the interface-select pin is high.
// - Bus mode with standby high and byte two D4 set: byte two D1 picks standard or high efficiency.
// - Bus mode: play needs mute pin high and byte one D2 set.
// - Standby pin low always turns off; bus mode turns on only by command.
// - Legacy mode: standby level picks standard or high efficiency, mute pin play.
// - Legacy mode: fault output low on any output short.
// - Low supply forces high efficiency off; it returns by itself on recovery.
// - Data line changes only while the bus clock is low.
// - Start is data falling, stop data rising, both with clock high.
// - Bytes are eight bits, MSB first, then one acknowledge bit.
// - Receiver pulls data low during acknowledge; transmitter releases it.
// - Address is fixed upper five bits plus two strapped bits, then R/W.
// - A write carries at most two instruction bytes, first then second.
// - A read returns at most two diagnostic bytes, first then second.
// - Byte one: D6 diagnostics, D5 offset detection, D4 gain 16 dB.
// - Byte one: D7 supply-mute threshold, D0 clip level, D3 D1 zero.
// - Byte two: D4 leaves standby, D5 enables fast muting.
// - Byte two: D7 current threshold, D3 line driver, D2 current diag.
// - Each read restarts diagnostics and returns the previous cycle result.
// - Result byte one D6 is zero until the diagnostic cycle terminates.
`timescale 1ns/1ps
module acp_top
	import acp_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic if_sel_pin,
	input wire logic hw_sleep_pin,
	input wire logic hw_sleep_hv,
	input wire logic mute_pin,
	input wire logic supply_low,
	input wire logic short_gnd,
	input wire logic short_vcc,
	input wire logic short_across,
	input wire logic meas_done,
	input wire logic [7:0] meas_one,
	input wire logic [7:0] meas_two,
	input wire logic [1:0] addr_strap,
	output logic amp_on,
	output logic play_en,
	output logic standard_drive_mode,
	output logic high_efficiency_drive_mode,
	output logic gain_16db,
	output logic diag_en,
	output logic offset_det_en,
	output logic supply_mute_high,
	output logic clip_detect_level,
	output logic current_thr_low,
	output logic line_driver_diag,
	output logic current_diag_en,
	output logic fast_mute_en,
	output logic fault_flag_out_n,
	output logic diag_restart
);
	typedef struct packed {
		acp_state_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rd;
		logic [1:0] idx;
		logic scl_p;
		logic sda_p;
		logic meas_p;
		logic [7:0] ctl_one;
		logic [7:0] ctl_two;
		logic [7:0] res_one;
		logic [7:0] res_two;
		logic done;
		logic oe_n;
		acp_mode_s mode;
		logic fault_n;
		logic restart;
	} acp_top_s;

	acp_top_s q, d;
	acp_pins_s raw, p;
	acp_mode_s mode_c;
	logic rise, fall, start_c, stop_c, any_short, addr_hit;
	logic [7:0] first_byte;

	assign raw = '{scl: scl, sda: sda_in, if_sel: if_sel_pin, sleep_on: hw_sleep_pin,
		sleep_hv: hw_sleep_hv, mute_on: mute_pin, supply_low: supply_low,
		short_gnd: short_gnd, short_vcc: short_vcc, short_across: short_across,
		meas_done: meas_done, strap: addr_strap};

	acp_sync #(
		.W($bits(acp_pins_s))
	) u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.async_in(raw),
		.sync_out(p)
	);

	acp_mode_sel u_mode (
		.pins(p),
		.ctl_one(q.ctl_one),
		.ctl_two(q.ctl_two),
		.mode(mode_c)
	);

	assign rise = p.scl && !q.scl_p;
	assign fall = !p.scl && q.scl_p;
	assign start_c = p.scl && q.scl_p && q.sda_p && !p.sda;
	assign stop_c = p.scl && q.scl_p && !q.sda_p && p.sda;
	assign any_short = p.short_gnd || p.short_vcc || p.short_across;
	assign addr_hit = (q.sh[7:1] == {ACP_ADDR_FIXED, p.strap});
	// Done flag travels in the first result byte
	assign first_byte = {q.res_one[7], q.done, q.res_one[5:0]};

	always_comb begin
		d = q;
		d.scl_p = p.scl;
		d.sda_p = p.sda;
		d.meas_p = p.meas_done;
		d.restart = 1'b0;
		d.mode = mode_c;
		d.fault_n = !(!p.if_sel && any_short);
		if (!p.if_sel) begin
			// Port disabled: state frozen at idle and the line released
			d.st = ACP_IDLE;
			d.oe_n = 1'b1;
		end else if (start_c) begin
			d.st = ACP_ADDR;
			d.cnt = 4'h0;
			d.oe_n = 1'b1;
		end else if (stop_c) begin
			d.st = ACP_IDLE;
			d.oe_n = 1'b1;
		end else begin
			unique case (q.st)
				ACP_IDLE: begin
					d.oe_n = 1'b1;
				end
				ACP_ADDR: begin
					if (rise) begin
						d.sh = {q.sh[6:0], p.sda};
						d.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == ACP_BYTE_BITS) begin
						if (addr_hit) begin
							d.st = ACP_AACK;
							d.oe_n = 1'b0;
							d.rd = q.sh[0];
						end else begin
							d.st = ACP_IDLE;
						end
					end
				end
				ACP_AACK: begin
					if (fall) begin
						d.cnt = 4'h0;
						if (q.rd) begin
							// Snapshot of the finished cycle goes out; a new cycle starts
							d.sh = first_byte;
							d.oe_n = first_byte[7];
							d.idx = 2'h1;
							d.restart = 1'b1;
							d.st = ACP_RDX;
						end else begin
							d.oe_n = 1'b1;
							d.idx = 2'h0;
							d.st = ACP_WRX;
						end
					end
				end
				ACP_WRX: begin
					if (rise) begin
						d.sh = {q.sh[6:0], p.sda};
						d.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == ACP_BYTE_BITS) begin
						if (q.idx < ACP_NUM_BYTES) begin
							// Reserved positions are stored as zero
							if (q.idx == 2'h0) begin
								d.ctl_one = q.sh & ACP_C1_MASK;
							end else begin
								d.ctl_two = q.sh & ACP_C2_MASK;
							end
							d.idx = q.idx + 2'h1;
							d.oe_n = 1'b0;
							d.st = ACP_WACK;
						end else begin
							// A third byte is refused by leaving it unacknowledged
							d.st = ACP_IDLE;
						end
					end
				end
				ACP_WACK: begin
					if (fall) begin
						d.oe_n = 1'b1;
						d.cnt = 4'h0;
						d.st = ACP_WRX;
					end
				end
				ACP_RDX: begin
					if (fall) begin
						if (q.cnt[2:0] == ACP_LAST_BIT) begin
							d.oe_n = 1'b1;
							d.cnt = 4'h0;
							d.st = ACP_RACK;
						end else begin
							d.sh = {q.sh[6:0], 1'b0};
							d.oe_n = q.sh[6];
							d.cnt = q.cnt + 4'h1;
						end
					end
				end
				ACP_RACK: begin
					if (rise && (p.sda || q.idx == ACP_NUM_BYTES)) begin
						// Host refused or both bytes gone: stay released
						d.st = ACP_IDLE;
					end else if (fall) begin
						d.sh = q.res_two;
						d.oe_n = q.res_two[7];
						d.idx = ACP_NUM_BYTES;
						d.cnt = 4'h0;
						d.st = ACP_RDX;
					end
				end
				default: begin
					d.st = ACP_IDLE;
					d.oe_n = 1'b1;
				end
			endcase
		end
		// Pulling standby low drops the run request, so turn-on needs a fresh command
		if (p.if_sel && !p.sleep_on) begin
			d.ctl_two[ACP_C2_RUN] = 1'b0;
		end
		// Completion wins over the restart issued in the same cycle
		if (d.restart) begin
			d.done = 1'b0;
		end
		if (p.meas_done && !q.meas_p) begin
			d.res_one = meas_one;
			d.res_two = meas_two;
			d.done = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.st <= ACP_IDLE;
			q.ctl_one <= ACP_C1_RESET;
			q.ctl_two <= ACP_C2_RESET;
			q.res_one <= ACP_RES_RESET;
			q.res_two <= ACP_RES_RESET;
			q.oe_n <= 1'b1;
			q.fault_n <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Open-drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe_n = q.oe_n;
	assign amp_on = q.mode.amp_on;
	assign play_en = q.mode.play;
	assign standard_drive_mode = q.mode.standard;
	assign high_efficiency_drive_mode = q.mode.high_eff;
	assign gain_16db = q.ctl_one[ACP_C1_GAIN_16DB];
	assign diag_en = q.ctl_one[ACP_C1_DIAG_EN];
	assign offset_det_en = q.ctl_one[ACP_C1_OFFSET_EN];
	assign supply_mute_high = q.ctl_one[ACP_C1_SUPPLY_THR];
	assign clip_detect_level = q.ctl_one[ACP_C1_CLIP_LEVEL];
	assign current_thr_low = q.ctl_two[ACP_C2_CUR_THR_LOW];
	assign line_driver_diag = q.ctl_two[ACP_C2_LINE_DRV];
	assign current_diag_en = q.ctl_two[ACP_C2_CUR_DIAG];
	assign fast_mute_en = q.ctl_two[ACP_C2_FAST_MUTE];
	assign fault_flag_out_n = q.fault_n;
	assign diag_restart = q.restart;

	a_legacy_fault: assert property (@(posedge clock) disable iff (!arst_n)
		(!p.if_sel && any_short) |=> !fault_flag_out_n)
		else $error("fault output not low on a short in legacy mode");

	a_sleep_off: assert property (@(posedge clock) disable iff (!arst_n)
		!p.sleep_on |=> !amp_on && !play_en)
		else $error("amplifier on while standby pin low");

	a_play_gate: assert property (@(posedge clock) disable iff (!arst_n)
		$past(p.if_sel) && play_en |-> $past(p.mute_on) && $past(q.ctl_one[ACP_C1_UNMUTE]))
		else $error("play without mute pin high and unmute bit");

	a_he_select: assert property (@(posedge clock) disable iff (!arst_n)
		$past(p.if_sel && p.sleep_on && q.ctl_two[ACP_C2_RUN] && !p.supply_low)
		|-> high_efficiency_drive_mode == $past(q.ctl_two[ACP_C2_HIGH_EFF]))
		else $error("drive mode does not follow byte two D1");

	a_he_supply: assert property (@(posedge clock) disable iff (!arst_n)
		p.supply_low |=> !high_efficiency_drive_mode)
		else $error("high efficiency kept at low supply");

	a_legacy_mode: assert property (@(posedge clock) disable iff (!arst_n)
		(!p.if_sel && p.sleep_on && !p.supply_low)
		|=> high_efficiency_drive_mode == $past(p.sleep_hv) && standard_drive_mode != $past(p.sleep_hv))
		else $error("legacy drive mode does not follow standby level");

	a_port_off: assert property (@(posedge clock) disable iff (!arst_n)
		!p.if_sel |=> sda_oe_n && q.st == ACP_IDLE)
		else $error("data line driven while port disabled");

	a_addr_ack: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(q.st == ACP_AACK) |-> $past(addr_hit) && !sda_oe_n)
		else $error("acknowledge on a foreign address");

	a_sda_stable: assert property (@(posedge clock) disable iff (!arst_n)
		(p.scl && q.scl_p) |=> $stable(sda_oe_n))
		else $error("data line changed while clock high");

	a_byte_bits: assert property (@(posedge clock) disable iff (!arst_n)
		q.cnt <= ACP_BYTE_BITS)
		else $error("bit counter past eight");

	a_restart_pulse: assert property (@(posedge clock) disable iff (!arst_n)
		diag_restart |=> !diag_restart)
		else $error("restart pulse longer than one cycle");

	a_done_clear: assert property (@(posedge clock) disable iff (!arst_n)
		diag_restart && !$past(p.meas_done && !q.meas_p) |-> !q.done)
		else $error("done flag not cleared by restart");

	a_write_store: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(q.st == ACP_WACK) && q.idx == 2'h1 |-> q.ctl_one == ($past(q.sh) & ACP_C1_MASK))
		else $error("first instruction byte not stored");

	a_sleep_rearm: assert property (@(posedge clock) disable iff (!arst_n)
		p.if_sel && $past(p.if_sel) && $rose(p.sleep_on) |=> !amp_on)
		else $error("amplifier on again without a bus command");

	a_third_refuse: assert property (@(posedge clock) disable iff (!arst_n)
		p.if_sel && q.st == ACP_WRX && fall && q.cnt == ACP_BYTE_BITS
		&& q.idx == ACP_NUM_BYTES |=> sda_oe_n && q.st == ACP_IDLE)
		else $error("third instruction byte acknowledged");
endmodule

// File: tb/acp_host_model.sv
// Host bus master model that drives the serial port from the far side
`timescale 1ns/1ps
module acp_host_model (
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	localparam int HP = 200;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// The clock stays high between frames, and data moves only while the clock is low, except at start and stop
	task automatic bit_io(input logic b, output logic r);
		#(HP / 4) sda_pull = !b;
		#(HP * 3 / 4) scl = 1'b1;
		#(HP / 2) r = sda;
		#(HP / 2) scl = 1'b0;
	endtask
	task automatic start();
		#HP sda_pull = 1'b0;
		scl = 1'b1;
		#HP sda_pull = 1'b1;
		#HP scl = 1'b0;
	endtask
	task automatic stop();
		#(HP / 4) sda_pull = 1'b1;
		#HP scl = 1'b1;
		#HP sda_pull = 1'b0;
		#HP;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(ack, r);
	endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the amplifier control serial port
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
	import acp_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic scl, sda_pull, sda, sda_out, sda_oe_n;
	logic if_sel = 1'b1, sleep = 1'b1, sleep_hv = 1'b0, mute = 1'b1, sup_low = 1'b0;
	logic [2:0] shorts = 3'h0;
	logic done = 1'b0;
	logic [7:0] m1 = 8'h00, m2 = 8'h00;
	logic [1:0] strap = 2'h2;
	logic amp_on, play_en, std_m, he_m, fault_n, restart;
	logic [8:0] ctl;
	logic [7:0] aw, ar;
	int errors = 0, checks = 0, restarts = 0;
	always #25 clock = ~clock;
	// Pull-up wins unless some party pulls the line low
	assign sda = sda_pull ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);
	assign aw = {ACP_ADDR_FIXED, strap, 1'b0};
	assign ar = {ACP_ADDR_FIXED, strap, 1'b1};
	always @(posedge clock) if (restart === 1'b1) restarts++;
	acp_host_model acp_host_model_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda));
	acp_top acp_top_inst (.clock(clock), .arst_n(arst_n), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .if_sel_pin(if_sel), .hw_sleep_pin(sleep),
		.hw_sleep_hv(sleep_hv), .mute_pin(mute), .supply_low(sup_low),
		.short_gnd(shorts[0]), .short_vcc(shorts[1]), .short_across(shorts[2]),
		.meas_done(done), .meas_one(m1), .meas_two(m2), .addr_strap(strap),
		.amp_on(amp_on), .play_en(play_en), .standard_drive_mode(std_m),
		.high_efficiency_drive_mode(he_m), .gain_16db(ctl[8]), .diag_en(ctl[7]),
		.offset_det_en(ctl[6]), .supply_mute_high(ctl[5]), .clip_detect_level(ctl[4]),
		.current_thr_low(ctl[3]), .line_driver_diag(ctl[2]), .current_diag_en(ctl[1]),
		.fast_mute_en(ctl[0]), .fault_flag_out_n(fault_n), .diag_restart(restart));
	// Pins pass two sync flops and one output register before they show
	task automatic settle();
		repeat (4) @(posedge clock);
		#2;
	endtask
	// A third byte follows each write so that its refusal is exercised whenever the port acknowledges the address
	task automatic wr(input logic [7:0] a, input logic [7:0] b1, input logic [7:0] b2,
		output logic [3:0] k);
		acp_host_model_inst.start();
		acp_host_model_inst.wbyte(a, k[3]);
		acp_host_model_inst.wbyte(b1, k[2]);
		acp_host_model_inst.wbyte(b2, k[1]);
		acp_host_model_inst.wbyte(~b1, k[0]);
		acp_host_model_inst.stop();
		settle();
	endtask
	task automatic rd(output logic [7:0] d1, output logic [7:0] d2);
		logic k;
		acp_host_model_inst.start();
		acp_host_model_inst.wbyte(ar, k);
		acp_host_model_inst.rbyte(1'b0, d1);
		acp_host_model_inst.rbyte(1'b1, d2);
		acp_host_model_inst.stop();
		settle();
		`CHK(k, 1'b1)
	endtask
	task automatic t_write();
		logic [3:0] k;
		`CHK(ctl, 9'h000)
		wr(aw, 8'hff, 8'hff, k);
		`CHK(k, 4'he)
		`CHK(ctl, 9'h1ff)
		`CHK({amp_on, play_en, he_m, std_m}, 4'he)
		sup_low = 1'b1;
		settle();
		`CHK(he_m, 1'b0)
		sup_low = 1'b0;
		settle();
		`CHK(he_m, 1'b1)
		mute = 1'b0;
		wr(aw, 8'h55, 8'h98, k);
		`CHK(ctl, 9'h19c)
		`CHK({amp_on, play_en, he_m, std_m}, 4'h9)
		mute = 1'b1;
		settle();
		`CHK(play_en, 1'b1)
		$display("write test done");
	endtask
	task automatic t_sleep_addr();
		logic [3:0] k;
		sleep = 1'b0;
		settle();
		`CHK(amp_on, 1'b0)
		sleep = 1'b1;
		wr(aw, 8'h00, 8'h00, k);
		`CHK(amp_on, 1'b0)
		wr(aw, 8'h00, 8'h10, k);
		`CHK(amp_on, 1'b1)
		wr({ACP_ADDR_FIXED, ~strap, 1'b0}, 8'hff, 8'hef, k);
		`CHK(k[3], 1'b0)
		wr({5'h0a, strap, 1'b0}, 8'hff, 8'hef, k);
		`CHK({k[3], amp_on, ctl}, {2'h1, 9'h000})
		$display("standby and address test done");
	endtask
	task automatic t_read();
		logic [7:0] d1, d2;
		m1 = 8'h85;
		m2 = 8'h3c;
		done = 1'b1;
		settle();
		rd(d1, d2);
		`CHK({d1, d2}, 16'hc53c)
		m1 = 8'h01;
		m2 = 8'h02;
		done = 1'b0;
		rd(d1, d2);
		`CHK({d1, d2}, 16'h853c)
		`CHK(restarts, 2)
		done = 1'b1;
		settle();
		rd(d1, d2);
		`CHK({d1, d2}, 16'h4102)
		$display("read test done");
	endtask
	// Measurement side: one finished diagnostic cycle with the given results
	task automatic meas(input logic [7:0] a, input logic [7:0] b);
		done = 1'b0;
		settle();
		m1 = a;
		m2 = b;
		done = 1'b1;
		settle();
	endtask
	// Reads, at most four times, until no flag under the mask is set; each read is followed by a clean cycle
	task automatic rd_until(input logic [7:0] mask, output int n);
		logic [7:0] d1, d2;
		n = 0;
		d1 = mask;
		d2 = mask;
		while (n < 4 && ((d1 | d2) & mask) != 8'h00) begin
			rd(d1, d2);
			meas(8'h00, 8'h00);
			n++;
		end
	endtask
	// The logic times none of the host's waits, so the sequences keep only their order
	task automatic t_host_seq();
		logic [3:0] k;
		int n;
		wr(aw, 8'h40, 8'h10, k);
		`CHK({amp_on, play_en, ctl[7]}, 3'h5)
		wr(aw, 8'h44, 8'h10, k);
		`CHK({amp_on, play_en, ctl[7]}, 3'h7)
		wr(aw, 8'h40, 8'h10, k);
		`CHK({amp_on, play_en}, 2'h2)
		sleep = 1'b0;
		settle();
		`CHK(amp_on, 1'b0)
		sleep = 1'b1;
		settle();
		`CHK(amp_on, 1'b0)
		wr(aw, 8'h40, 8'h10, k);
		meas(8'h01, 8'h02);
		rd_until(8'h3f, n);
		`CHK(n, 2)
		wr(aw, 8'h64, 8'h10, k);
		`CHK({play_en, ctl[6]}, 2'h3)
		meas(8'h04, 8'h00);
		rd_until(8'h04, n);
		`CHK(n, 2)
		$display("host sequence test done");
	endtask
	task automatic t_legacy();
		logic [3:0] k;
		if_sel = 1'b0;
		wr(aw, 8'h00, 8'h00, k);
		`CHK({k, amp_on}, 5'h01)
		`CHK({amp_on, play_en, he_m, std_m}, 4'hd)
		sleep_hv = 1'b1;
		settle();
		`CHK({amp_on, play_en, he_m, std_m}, 4'he)
		mute = 1'b0;
		settle();
		`CHK(play_en, 1'b0)
		for (int i = 0; i < 3; i++) begin
			shorts = 3'h1 << i;
			settle();
			`CHK(fault_n, 1'b0)
			shorts = 3'h0;
			settle();
			`CHK(fault_n, 1'b1)
		end
		$display("legacy test done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clock);
		#2 arst_n = 1'b1;
		settle();
		t_write();
		t_sleep_addr();
		t_read();
		t_host_seq();
		t_legacy();
		report_and_stop();
	end
	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		report_and_stop();
	end
endmodule
